//--- fxcap_pkg.sv
package fxcap_pkg;

	// ****************************************************************
	// control register numbers, as given to the move instructions
	// ****************************************************************
	localparam logic [5:0] FXCAP_CR_HS1 = 6'h01; // src1_operand_high_capture
	localparam logic [5:0] FXCAP_CR_LS1 = 6'h02; // src1_operand_low_capture
	localparam logic [5:0] FXCAP_CR_HS2 = 6'h03; // src2_operand_high_capture
	localparam logic [5:0] FXCAP_CR_LS2 = 6'h04; // src2_operand_low_capture
	localparam logic [5:0] FXCAP_CR_PPT = 6'h05; // precise_op_type_capture
	localparam logic [5:0] FXCAP_CR_PRH = 6'h06; // partial_result_high_capture
	localparam logic [5:0] FXCAP_CR_IPT = 6'h08; // imprecise_op_type_capture
	localparam logic [5:0] FXCAP_CR_CTL = 6'h3F; // user_round_and_handler_enables

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int FXCAP_CTL_RM_LSB = 14; // rounding_select in bits 15-14
	localparam int FXCAP_IPT_ENA_LSB = 5; // enable snapshots in bits 9-5
	localparam int FXCAP_IPT_EXP_LSB = 20; // result_exponent_field in bits 31-20
	localparam int FXCAP_PRH_RM_LSB = 29; // applied_rounding_field in bits 30-29

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] FXCAP_RST_WORD = 32'h0000_0000;
	localparam logic [1:0] FXCAP_RST_RM = 2'h0;
	localparam logic [4:0] FXCAP_RST_ENA = 5'h00;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		FXCAP_RM_NEAREST = 2'h0,
		FXCAP_RM_ZERO = 2'h1,
		FXCAP_RM_NEG_INF = 2'h2,
		FXCAP_RM_POS_INF = 2'h3
	} fxcap_rm_e;

	// five handler enables, msb first as in the control word
	typedef struct packed {
		logic invalid_handler_enable;
		logic divzero_handler_enable;
		logic underflow_handler_enable;
		logic overflow_handler_enable;
		logic inexact_handler_enable;
	} fxcap_ena_s;

	// one-hot decode of the rounding select
	typedef struct packed {
		logic to_nearest;
		logic to_zero;
		logic to_neg_inf;
		logic to_pos_inf;
	} fxcap_rnd_s;

	// one source operand as the pipeline holds it
	typedef struct packed {
		logic is_int; // 32-bit integer in val[31:0]
		logic is_dbl; // double in val[63:0], else single in val[31:0]
		logic [63:0] val;
	} fxcap_op_s;

	// precise exception capture data
	typedef struct packed {
		logic idiv_err; // integer divide error
		logic [10:0] instr_15_5; // opcode and three size fields
		logic [4:0] destination_number_field_num;
		fxcap_op_s src1;
		fxcap_op_s src2;
	} fxcap_prec_s;

	// imprecise exception capture data
	typedef struct packed {
		logic [4:0] opcode; // instruction bits 15-11
		logic instr_b5; // destination size bit
		logic [4:0] destination_number_field_num;
		logic res_dbl; // exponent is 11 bits, else 8 bits in res_exp[7:0]
		logic [10:0] res_exp; // biased result exponent
		logic sign;
		logic guard;
		logic round;
		logic sticky;
		logic increment_applied_flag;
		logic [20:0] mant_hi; // includes hidden bit
	} fxcap_imp_s;

endpackage

//--- fxcap_regs.sv
`timescale 1ns/1ns
// What this block does
// - rounding field decodes nearest, zero, minus, plus
// - each enable bit: 0 disabled, 1 enabled
// - inexact disabled: default handling, no vectoring
// - only inexact enable and rounding steer hardware
// - operand high: sign, exponent, top 20 mantissa
// - divide error zeroes src1 high mantissa
// - operand low: double word, single bits, integer
// - src2 low holds integer divide/convert operand
// - operands captured on every precise exception
// - capture registers read-only, writes ignored
// - precise type: zeros, opcode/sizes, destination number
// - size fields: 00 single, 01 double
// - precise type undefined for integer multiply
// - imprecise type layout: exponent, opcode, flags, destination
// - result exponent: msb inverted and extended
// - destination size flag from instruction bit 5
// - enable snapshots taken at instruction initiation
// - partial result high layout with rounding flags
// - applied rounding taken at instruction initiation
// - add-one and guard/round/sticky copied from result
// - reserved fields read zero, ignore writes
// - precise and imprecise captures load separately
module fxcap_regs
(
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [5:0] cr_sel_i, // control register number
	input wire logic cr_rd_i, // read strobe
	input wire logic cr_wr_i, // write strobe
	input wire logic [31:0] cr_wdata_i,
	input wire logic issue_i, // an instruction enters the unit
	input wire logic prec_exc_i, // precise or integer-divide exception
	input wire fxcap_pkg::fxcap_prec_s prec_i,
	input wire logic imp_exc_i, // imprecise exception
	input wire fxcap_pkg::fxcap_imp_s imp_i,
	input wire logic inexact_cond_i, // inexact result detected
	output logic [31:0] cr_rdata_o,
	output fxcap_pkg::fxcap_rnd_s round_mode_o,
	output logic inexact_handler_enable_o,
	output logic inexact_vector_o, // vector to the inexact handler
	output logic default_inexact_o // hardware handles inexact itself
);
	import fxcap_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	fxcap_rm_e rounding_select_q; // live rounding select
	fxcap_ena_s ena_q; // live handler enables
	fxcap_rm_e rm_snap_q; // rounding at instruction initiation
	fxcap_ena_s ena_snap_q; // enables at instruction initiation
	logic [31:0] hs1_q;
	logic [31:0] ls1_q;
	logic [31:0] hs2_q;
	logic [31:0] ls2_q;
	logic [31:0] ppt_q;
	logic [31:0] ipt_q;
	logic [31:0] prh_q;
	logic [31:0] ctl_word; // control word as read back
	logic [11:0] res_exp_fmt; // formatted result exponent
	logic [31:0] rdata_d;
	logic [31:0] hs1_fmt; // src1 high word before the divide-error mask

	// ****************************************************************
	// operand formatting
	// ****************************************************************
	// high word: sign, 11-bit exponent, top 20 mantissa bits
	function automatic logic [31:0] fmt_hi(input fxcap_op_s op);
		logic [31:0] w;
		w = FXCAP_RST_WORD;
		if (op.is_int)
			w = FXCAP_RST_WORD; // undefined, kept zero
		else if (op.is_dbl)
			w = op.val[63:32];
		else
			w = {op.val[31], {3{op.val[30]}}, op.val[30:23], op.val[22:3]};
		return w;
	endfunction

	// low word: double low word, single low 3 bits, or integer
	function automatic logic [31:0] fmt_lo(input fxcap_op_s op);
		logic [31:0] w;
		w = FXCAP_RST_WORD;
		if (op.is_int)
			w = op.val[31:0];
		else if (op.is_dbl)
			w = op.val[31:0];
		else
			w = {op.val[2:0], 29'h0000_0000};
		return w;
	endfunction

	// formatted once, since a function result cannot be part-selected
	assign hs1_fmt = fmt_hi(prec_i.src1);

	// ****************************************************************
	// user control register
	// ****************************************************************
	// only rounding and five enables are stored; other bits are not kept
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rounding_select_q <= FXCAP_RM_NEAREST;
			ena_q <= FXCAP_RST_ENA;
		end
		else if (cr_wr_i && cr_sel_i == FXCAP_CR_CTL)
		begin
			rounding_select_q <= fxcap_rm_e'(cr_wdata_i[FXCAP_CTL_RM_LSB +: 2]);
			ena_q <= cr_wdata_i[4:0];
		end
	end

	assign ctl_word = {16'h0000, rounding_select_q, 9'h000, ena_q};

	// ****************************************************************
	// initiation snapshot
	// ****************************************************************
	// exceptions arrive late, so the settings of the faulting
	// instruction are frozen when it is issued
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rm_snap_q <= FXCAP_RM_NEAREST;
			ena_snap_q <= FXCAP_RST_ENA;
		end
		else if (issue_i)
		begin
			rm_snap_q <= rounding_select_q;
			ena_snap_q <= ena_q;
		end
	end

	// ****************************************************************
	// precise captures
	// ****************************************************************
	// loaded only by a precise exception; no write path reaches them
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			hs1_q <= FXCAP_RST_WORD;
			ls1_q <= FXCAP_RST_WORD;
			hs2_q <= FXCAP_RST_WORD;
			ls2_q <= FXCAP_RST_WORD;
			ppt_q <= FXCAP_RST_WORD;
		end
		else if (prec_exc_i)
		begin
			// divide error: mantissa zero, sign and exponent left as found
			if (prec_i.idiv_err)
				hs1_q <= {hs1_fmt[31:20], 20'h0_0000};
			else
				hs1_q <= hs1_fmt;
			ls1_q <= fmt_lo(prec_i.src1);
			hs2_q <= fmt_hi(prec_i.src2);
			ls2_q <= fmt_lo(prec_i.src2);
			// size fields' upper bits cleared; integer multiply gives no meaning here
			ppt_q <= {16'h0000, prec_i.instr_15_5[10:6], 1'b0, prec_i.instr_15_5[4], 1'b0,
				prec_i.instr_15_5[2], 1'b0, prec_i.instr_15_5[0], prec_i.destination_number_field_num};
		end
	end

	// ****************************************************************
	// imprecise captures
	// ****************************************************************
	// result exponent: invert the msb and extend it to 12 bits
	always_comb
	begin
		if (imp_i.res_dbl)
			res_exp_fmt = {{2{~imp_i.res_exp[10]}}, imp_i.res_exp[9:0]};
		else
			res_exp_fmt = {{5{~imp_i.res_exp[7]}}, imp_i.res_exp[6:0]};
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ipt_q <= FXCAP_RST_WORD;
			prh_q <= FXCAP_RST_WORD;
		end
		else if (imp_exc_i)
		begin
			ipt_q <= {res_exp_fmt, 4'h0, imp_i.opcode, imp_i.instr_b5, ena_snap_q,
				imp_i.destination_number_field_num};
			prh_q <= {imp_i.sign, rm_snap_q, imp_i.guard, imp_i.round, imp_i.sticky,
				imp_i.increment_applied_flag, 4'h0, imp_i.mant_hi};
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	// unmapped numbers (cause, status, result low) read zero here
	always_comb
	begin
		unique case (cr_sel_i)
			FXCAP_CR_HS1: rdata_d = hs1_q;
			FXCAP_CR_LS1: rdata_d = ls1_q;
			FXCAP_CR_HS2: rdata_d = hs2_q;
			FXCAP_CR_LS2: rdata_d = ls2_q;
			FXCAP_CR_PPT: rdata_d = ppt_q;
			FXCAP_CR_PRH: rdata_d = prh_q;
			FXCAP_CR_IPT: rdata_d = ipt_q;
			FXCAP_CR_CTL: rdata_d = ctl_word;
			default: rdata_d = FXCAP_RST_WORD;
		endcase
	end

	// read data lands one cycle after the strobe and holds until the next read
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
			cr_rdata_o <= FXCAP_RST_WORD;
		else if (cr_rd_i)
			cr_rdata_o <= rdata_d;
	end

	// ****************************************************************
	// hardware use of the control register
	// ****************************************************************
	// only rounding and the inexact enable leave the register
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			round_mode_o <= 4'h8;
			inexact_handler_enable_o <= 1'b0;
		end
		else
		begin
			round_mode_o.to_nearest <= (rounding_select_q == FXCAP_RM_NEAREST);
			round_mode_o.to_zero <= (rounding_select_q == FXCAP_RM_ZERO);
			round_mode_o.to_neg_inf <= (rounding_select_q == FXCAP_RM_NEG_INF);
			round_mode_o.to_pos_inf <= (rounding_select_q == FXCAP_RM_POS_INF);
			inexact_handler_enable_o <= ena_q.inexact_handler_enable;
		end
	end

	// inexact: vector when enabled, otherwise default handling in hardware
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			inexact_vector_o <= 1'b0;
			default_inexact_o <= 1'b0;
		end
		else
		begin
			inexact_vector_o <= inexact_cond_i && ena_q.inexact_handler_enable;
			default_inexact_o <= inexact_cond_i && !ena_q.inexact_handler_enable;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_ctl_write;
		cr_wr_i && cr_sel_i == FXCAP_CR_CTL;
	endsequence

	sequence s_ctl_readback;
		cr_rd_i && cr_sel_i == FXCAP_CR_CTL;
	endsequence

	// an issue directly followed by its imprecise exception
	sequence s_issue_then_imp;
		issue_i ##1 (!issue_i && imp_exc_i);
	endsequence

	a_ctl_write_mask: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_ctl_write ##1 s_ctl_readback |=> cr_rdata_o == ($past(cr_wdata_i, 2) & 32'h0000_C01F))
		else $error("control write not masked on readback");

	a_ro_capture_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		cr_wr_i && !prec_exc_i && !imp_exc_i |=> $stable(hs1_q) && $stable(ppt_q) && $stable(prh_q))
		else $error("capture changed by a write");

	a_inexact_default: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		inexact_cond_i && !ena_q.inexact_handler_enable |=> default_inexact_o && !inexact_vector_o)
		else $error("inexact vectored while disabled");

	a_inexact_vector: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		inexact_cond_i && ena_q.inexact_handler_enable |=> inexact_vector_o && !default_inexact_o)
		else $error("inexact not vectored while enabled");

	a_round_decode: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_ctl_write ##2 1'b1 |-> round_mode_o == (4'h8 >> $past(cr_wdata_i[FXCAP_CTL_RM_LSB +: 2], 2)))
		else $error("rounding decode wrong");

	a_divide_mantissa: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i && prec_i.idiv_err |=> hs1_q[19:0] == 20'h0_0000)
		else $error("divide error mantissa not zero");

	a_ppt_reserved: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i |=> ppt_q[31:16] == 16'h0000 && !ppt_q[10] && !ppt_q[8] && !ppt_q[6])
		else $error("precise type reserved bits set");

	a_single_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i && !prec_i.src2.is_int && !prec_i.src2.is_dbl |=>
		ls2_q[28:0] == 29'h0000_0000 && ls2_q[31:29] == $past(prec_i.src2.val[2:0]))
		else $error("single low word wrong");

	a_snapshot_enables: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_issue_then_imp |=> ipt_q[9:5] == $past(ena_q, 2))
		else $error("enable snapshot not from initiation");

	a_single_exponent: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		imp_exc_i && !imp_i.res_dbl |=> ipt_q[31:27] == {5{~$past(imp_i.res_exp[7])}} && ipt_q[19:16] == 4'h0)
		else $error("single result exponent wrong");

	a_capture_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(!prec_exc_i && !imp_exc_i) [*2] |=> $stable(ls2_q) && $stable(ipt_q))
		else $error("capture changed without exception");

	// ****************************************************************
	// capture contents
	// ****************************************************************
	a_double_high: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i && prec_i.src1.is_dbl && !prec_i.src1.is_int && !prec_i.idiv_err |=>
		hs1_q == $past(prec_i.src1.val[63:32]))
		else $error("double high word not captured");

	a_int_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i && prec_i.src2.is_int |=>
		ls2_q == $past(prec_i.src2.val[31:0]))
		else $error("integer operand not captured");

	a_ppt_fields: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i |=>
		ppt_q[15:11] == $past(prec_i.instr_15_5[10:6]) && ppt_q[4:0] == $past(prec_i.destination_number_field_num))
		else $error("precise type opcode or destination wrong");

	a_ppt_sizes: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i |=> ppt_q[9] == $past(prec_i.instr_15_5[4]) &&
		ppt_q[7] == $past(prec_i.instr_15_5[2]) && ppt_q[5] == $past(prec_i.instr_15_5[0]))
		else $error("precise type size bits wrong");

	// imprecise words come from the exception data and the issue snapshot
	a_double_exponent: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		imp_exc_i && imp_i.res_dbl |=>
		ipt_q[31:30] == {2{~$past(imp_i.res_exp[10])}} && ipt_q[29:20] == $past(imp_i.res_exp[9:0]))
		else $error("double result exponent wrong");

	a_destsize_copy: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		imp_exc_i |=> ipt_q[10] == $past(imp_i.instr_b5) && ipt_q[15:11] == $past(imp_i.opcode))
		else $error("destination size or opcode wrong");

	a_rm_snapshot: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_issue_then_imp |=> prh_q[30:29] == $past(rounding_select_q, 2))
		else $error("rounding snapshot not from initiation");

	a_result_flags: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		imp_exc_i |=>
		prh_q[28:25] == $past({imp_i.guard, imp_i.round, imp_i.sticky, imp_i.increment_applied_flag}))
		else $error("rounding flags wrong");

	a_prh_layout: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		imp_exc_i |=> prh_q[24:21] == 4'h0 && prh_q[20:0] == $past(imp_i.mant_hi) &&
		prh_q[31] == $past(imp_i.sign))
		else $error("partial result layout wrong");

	// control storage and which exception loads which capture
	a_ena_stored: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_ctl_write |=> ena_q == $past(cr_wdata_i[4:0]))
		else $error("handler enables not stored");

	a_round_onehot: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$onehot(round_mode_o))
		else $error("rounding decode not one-hot");

	a_prec_only: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		prec_exc_i && !imp_exc_i |=> $stable(ipt_q) && $stable(prh_q))
		else $error("precise exception loaded imprecise capture");

	a_imp_only: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		imp_exc_i && !prec_exc_i |=> $stable(hs1_q) && $stable(ls1_q) && $stable(ppt_q))
		else $error("imprecise exception loaded precise capture");

endmodule

//--- test_fpu_exception_capture_regs.sv
`timescale 1ns/1ns
// ****************************************************************
// bench for the exception capture registers
// ****************************************************************
module test_fpu_exception_capture_regs;
	import fxcap_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0; // held low for 16 cycles
	logic [5:0] cr_sel_i = 6'h00;
	logic cr_rd_i = 1'b0;
	logic cr_wr_i = 1'b0;
	logic [31:0] cr_wdata_i = 32'h00000000;
	logic issue_i = 1'b0;
	logic prec_exc_i = 1'b0;
	logic imp_exc_i = 1'b0;
	logic inexact_cond_i = 1'b0;
	fxcap_prec_s prec_i = '0;
	fxcap_imp_s imp_i = '0;
	logic [31:0] cr_rdata_o;
	fxcap_rnd_s round_mode_o;
	logic inexact_handler_enable_o;
	logic inexact_vector_o;
	logic default_inexact_o;
	int n_errors = 0;
	int samples_checked = 0;

	fxcap_regs u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cr_sel_i(cr_sel_i), .cr_rd_i(cr_rd_i),
		.cr_wr_i(cr_wr_i), .cr_wdata_i(cr_wdata_i), .issue_i(issue_i), .prec_exc_i(prec_exc_i),
		.prec_i(prec_i), .imp_exc_i(imp_exc_i), .imp_i(imp_i), .inexact_cond_i(inexact_cond_i),
		.cr_rdata_o(cr_rdata_o), .round_mode_o(round_mode_o),
		.inexact_handler_enable_o(inexact_handler_enable_o), .inexact_vector_o(inexact_vector_o),
		.default_inexact_o(default_inexact_o));

	// 25 MHz system clock
	always #20 clk_sys_i = ~clk_sys_i;

	// ****************************************************************
	// shared helpers
	// ****************************************************************
	// word compare, case equality so unknowns never match
	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// flag compare
	task automatic chk_flag(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask

	// inputs move at the falling edge, strobes last one rising edge
	task automatic cr_write(input logic [5:0] sel, input logic [31:0] data);
		@(negedge clk_sys_i);
		cr_sel_i = sel;
		cr_wdata_i = data;
		cr_wr_i = 1'b1;
		@(negedge clk_sys_i);
		cr_wr_i = 1'b0;
	endtask

	// read data is registered, so it is settled at the next falling edge
	task automatic read_chk(input string name, input logic [5:0] sel, input logic [31:0] mask,
		input logic [31:0] exp);
		@(negedge clk_sys_i);
		cr_sel_i = sel;
		cr_rd_i = 1'b1;
		@(negedge clk_sys_i);
		cr_rd_i = 1'b0;
		chk_word(name, exp & mask, cr_rdata_o & mask);
	endtask

	// one-cycle event pulse: 0 issue, 1 precise, 2 imprecise, 3 inexact
	task automatic fire(input int kind);
		@(negedge clk_sys_i);
		case (kind)
			0: issue_i = 1'b1;
			1: prec_exc_i = 1'b1;
			2: imp_exc_i = 1'b1;
			default: inexact_cond_i = 1'b1;
		endcase
		@(negedge clk_sys_i);
		{issue_i, prec_exc_i, imp_exc_i, inexact_cond_i} = 4'h0;
	endtask

	// issue at one edge, its imprecise exception at the very next
	task automatic issue_then_imp();
		@(negedge clk_sys_i);
		issue_i = 1'b1;
		@(negedge clk_sys_i);
		issue_i = 1'b0;
		imp_exc_i = 1'b1;
		@(negedge clk_sys_i);
		imp_exc_i = 1'b0;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// control word: reserved bits dropped, every rounding code decoded
	task automatic t_control();
		read_chk("ctl reset", FXCAP_CR_CTL, 32'hFFFFFFFF, 32'h00000000);
		// write and read back to back, as software may do
		@(negedge clk_sys_i);
		cr_sel_i = FXCAP_CR_CTL;
		cr_wdata_i = 32'hFFFFFFFF;
		cr_wr_i = 1'b1;
		@(negedge clk_sys_i);
		cr_wr_i = 1'b0;
		cr_rd_i = 1'b1;
		@(negedge clk_sys_i);
		cr_rd_i = 1'b0;
		chk_word("ctl reserved", 32'h0000C01F, cr_rdata_o);
		for (int rm = 0; rm < 4; rm++)
		begin
			cr_write(FXCAP_CR_CTL, 32'(rm) << FXCAP_CTL_RM_LSB);
			@(negedge clk_sys_i);
			chk_word("round mode", 32'h8 >> rm, {28'h0, round_mode_o});
		end
		read_chk("unmapped", 6'h07, 32'hFFFFFFFF, 32'h00000000);
	endtask

	// inexact steering follows only its own enable
	task automatic t_inexact();
		cr_write(FXCAP_CR_CTL, 32'h0000001E);
		@(negedge clk_sys_i);
		chk_flag("inx enable", 1'b0, inexact_handler_enable_o);
		fire(3);
		chk_flag("default inx", 1'b1, default_inexact_o);
		chk_flag("vector inx", 1'b0, inexact_vector_o);
		cr_write(FXCAP_CR_CTL, 32'h00000001);
		@(negedge clk_sys_i);
		chk_flag("inx enable", 1'b1, inexact_handler_enable_o);
		fire(3);
		chk_flag("default inx", 1'b0, default_inexact_o);
		chk_flag("vector inx", 1'b1, inexact_vector_o);
	endtask

	// double first operand, single second operand
	task automatic t_precise();
		prec_i = '0;
		prec_i.instr_15_5 = 11'h7FF;
		prec_i.destination_number_field_num = 5'h1A;
		prec_i.src1.is_dbl = 1'b1;
		prec_i.src1.val = 64'hC123456789ABCDEF;
		prec_i.src2.val = 64'h000000004234567D;
		fire(1);
		read_chk("hs1", FXCAP_CR_HS1, 32'hFFFFFFFF, 32'hC1234567);
		read_chk("ls1", FXCAP_CR_LS1, 32'hFFFFFFFF, 32'h89ABCDEF);
		read_chk("hs2", FXCAP_CR_HS2, 32'hFFFFFFFF, 32'h78468ACF);
		read_chk("ls2", FXCAP_CR_LS2, 32'hFFFFFFFF, 32'hA0000000);
		read_chk("ppt", FXCAP_CR_PPT, 32'hFFFFFFFF, 32'h0000FABA);
		cr_write(FXCAP_CR_HS1, 32'h00000000);
		read_chk("hs1 write", FXCAP_CR_HS1, 32'hFFFFFFFF, 32'hC1234567);
	endtask

	// integer divide error, integer operands
	task automatic t_divide();
		prec_i = '0;
		prec_i.idiv_err = 1'b1;
		prec_i.destination_number_field_num = 5'h03;
		prec_i.src1.is_int = 1'b1;
		prec_i.src1.val = 64'h5555555580000007;
		prec_i.src2.is_int = 1'b1;
		prec_i.src2.val = 64'h00000000FFFFFFFE;
		fire(1);
		read_chk("hs1 mant", FXCAP_CR_HS1, 32'h000FFFFF, 32'h00000000);
		read_chk("ls1 int", FXCAP_CR_LS1, 32'hFFFFFFFF, 32'h80000007);
		read_chk("ls2 int", FXCAP_CR_LS2, 32'hFFFFFFFF, 32'hFFFFFFFE);
		read_chk("ppt destination_number_field", FXCAP_CR_PPT, 32'h0000001F, 32'h00000003);
		// a non-zero mantissa must still be cleared on a divide error
		prec_i.src1.is_int = 1'b0;
		prec_i.src1.is_dbl = 1'b1;
		fire(1);
		read_chk("hs1 dbl mant", FXCAP_CR_HS1, 32'h000FFFFF, 32'h00000000);
	endtask

	// snapshots come from issue time, not from exception time
	task automatic t_imprecise();
		cr_write(FXCAP_CR_CTL, 32'h00008015);
		fire(0);
		cr_write(FXCAP_CR_CTL, 32'h0000400A);
		imp_i = '0;
		imp_i.opcode = 5'h13;
		imp_i.instr_b5 = 1'b1;
		imp_i.destination_number_field_num = 5'h07;
		imp_i.res_dbl = 1'b1;
		imp_i.res_exp = 11'h3FF;
		imp_i.sign = 1'b1;
		imp_i.guard = 1'b1;
		imp_i.sticky = 1'b1;
		imp_i.increment_applied_flag = 1'b1;
		imp_i.mant_hi = 21'h1ABCDE;
		fire(2);
		read_chk("ipt dbl", FXCAP_CR_IPT, 32'hFFFFFFFF, 32'hFFF09EA7);
		read_chk("prh", FXCAP_CR_PRH, 32'hFFFFFFFF, 32'hD61ABCDE);
		read_chk("ls1 kept", FXCAP_CR_LS1, 32'hFFFFFFFF, 32'h80000007);
		imp_i.res_dbl = 1'b0;
		imp_i.res_exp = 11'h080;
		imp_i.instr_b5 = 1'b0;
		fire(2);
		read_chk("ipt sgl", FXCAP_CR_IPT, 32'hFFFFFFFF, 32'h00009AA7);
		issue_then_imp();
		read_chk("ipt reissue", FXCAP_CR_IPT, 32'hFFFFFFFF, 32'h00009947);
		read_chk("prh reissue", FXCAP_CR_PRH, 32'hFFFFFFFF, 32'hB61ABCDE);
	endtask

	// ****************************************************************
	// run control
	// ****************************************************************
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog: the full sequence needs well under 300 cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys_i);
		n_errors++;
		$display("BAD watchdog expected finish seen timeout");
		complete_run();
	end

	initial
	begin
		repeat (16) @(negedge clk_sys_i);
		chk_word("rm in reset", 32'h8, {28'h0, round_mode_o});
		rstn_i = 1'b1;
		t_control();
		t_inexact();
		t_precise();
		t_divide();
		t_imprecise();
		complete_run();
	end
endmodule
